// ---- rtl/srlc_pkg.sv ----
package srlc_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [11:0] LATCH_CONTROL_0_OFFS   = 12'h000;
   localparam logic [11:0] LATCH_CONTROL_1_OFFS   = 12'h004;
   localparam logic [11:0] LATCH_STATUS_OFFS      = 12'h008;
   localparam logic [7:0]  LATCH_CONTROL_0_RESET  = 8'h00;
   localparam logic [7:0]  LATCH_CONTROL_1_RESET  = 8'h00;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int LATCH_ENABLE_POS     = 7;
   localparam int DIVIDER_LSB_POS      = 4;
   localparam int TRUE_OE_POS          = 3;
   localparam int INV_OE_POS           = 2;
   localparam int SOFT_SET_POS         = 1;
   localparam int SOFT_RESET_POS       = 0;
   localparam int SET_CLOCK_EN_POS     = 0;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS        = 10;
   localparam int DIV_BASE_LOG2        = 2;
   localparam int DIV_COUNT_W          = 9;
   localparam int INSTR_CLOCK_DIV      = 4;

   typedef struct packed {
      logic       latch_enable_bit;
      logic [2:0] latch_pulse_divider;
      logic       true_output_enable;
      logic       inverted_output_enable;
   } srlc_ctrl_t;

   typedef struct packed {
      logic c1_set;
      logic c2_set;
      logic ext_set;
      logic c1_reset;
      logic c2_reset;
      logic ext_reset;
   } srlc_src_t;
endpackage

// ---- rtl/srlc_pulse_gen.sv ----
module srlc_pulse_gen
   import srlc_pkg::*;
#(
   parameter int COUNT_W = DIV_COUNT_W
) (
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic [2:0] divider,
   output logic            pulse
);
   logic [COUNT_W-1:0] count;
   logic [COUNT_W-1:0] mask;

   // Period is 4 << code; mask selects the low bits that must wrap
   assign mask = COUNT_W'((1 << (DIV_BASE_LOG2 + int'(divider))) - 1);

   // Free-running; a code change takes effect at the next wrap of the low bits
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         count <= '0;
         pulse <= 1'b0;
      end else begin
         count <= count + COUNT_W'(1);
         pulse <= ((count & mask) == mask);
      end
   end
endmodule

// ---- rtl/srlc_top.sv ----
module srlc_top (
   input  wire logic                mclk,
   input  wire logic                reset_n,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire srlc_pkg::srlc_src_t src_in,
   input  wire logic                external_latch_input,
   output logic                     true_output_pin,
   output logic                     true_output_oe_n,
   output logic                     inverted_output_pin,
   output logic                     inverted_output_oe_n
);
   import srlc_pkg::*;

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   srlc_ctrl_t  ctrl;
   logic        set_clock_enable;
   logic        soft_set_pulse;
   logic        soft_reset_pulse;
   logic [1:0]  instr_phase;
   logic        latch_q;
   logic        gen_pulse;
   logic [2:0]  ext_sync;
   logic        ext_level;
   logic        set_in;
   logic        reset_in;
   logic        wr_en;
   logic        addr_ok;
   logic        sel_ctrl0;
   logic        sel_ctrl1;
   logic        sel_status;
   logic        soft_wr;
   logic        soft_done;

   // ------------------------------------------------------------
   // Bus decode; zero wait states
   // ------------------------------------------------------------
   assign pready  = 1'b1;
   assign sel_ctrl0  = (paddr == LATCH_CONTROL_0_OFFS);
   assign sel_ctrl1  = (paddr == LATCH_CONTROL_1_OFFS);
   assign sel_status = (paddr == LATCH_STATUS_OFFS);
   assign addr_ok    = sel_ctrl0 || sel_ctrl1 || sel_status;
   assign pslverr = psel && penable && !addr_ok;
   assign wr_en   = psel && penable && pwrite && pstrb[0];

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   // Pulse bits are not stored here, so they can never read back
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ctrl <= srlc_ctrl_t'(LATCH_CONTROL_0_RESET[7:2]);
      end else if (wr_en && sel_ctrl0) begin
         ctrl <= srlc_ctrl_t'(pwdata[7:2]);
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         set_clock_enable <= LATCH_CONTROL_1_RESET[SET_CLOCK_EN_POS];
      end else if (wr_en && sel_ctrl1) begin
         set_clock_enable <= pwdata[SET_CLOCK_EN_POS];
      end
   end

   // ------------------------------------------------------------
   // Soft set/reset pulses, one instruction clock (4 mclk) long
   // ------------------------------------------------------------
   assign soft_wr   = wr_en && sel_ctrl0 && (pwdata[SOFT_SET_POS] || pwdata[SOFT_RESET_POS]);
   assign soft_done = (instr_phase == 2'(INSTR_CLOCK_DIV - 1));

   // Phase only runs while a pulse is out; a new soft write restarts it
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         instr_phase <= 2'h0;
      end else if (soft_wr) begin
         instr_phase <= 2'h0;
      end else if (soft_set_pulse || soft_reset_pulse) begin
         instr_phase <= instr_phase + 2'h1;
      end
   end

   // Writing 0 leaves a pulse in progress alone; a new write beats its end
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         soft_set_pulse <= 1'b0;
      end else if (soft_wr) begin
         soft_set_pulse <= soft_set_pulse | pwdata[SOFT_SET_POS];
      end else if (soft_done) begin
         soft_set_pulse <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         soft_reset_pulse <= 1'b0;
      end else if (soft_wr) begin
         soft_reset_pulse <= soft_reset_pulse | pwdata[SOFT_RESET_POS];
      end else if (soft_done) begin
         soft_reset_pulse <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Read path; pulse bits always read zero
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            LATCH_CONTROL_0_OFFS: prdata <= {24'h0, ctrl, 2'b00};
            LATCH_CONTROL_1_OFFS: prdata <= {31'h0, set_clock_enable};
            LATCH_STATUS_OFFS:    prdata <= {31'h0, latch_q};
            default:              prdata <= 32'h0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pulse generator and external input
   // ------------------------------------------------------------
   srlc_pulse_gen #(
      .COUNT_W (DIV_COUNT_W)
   ) u_pulse_gen (
      .mclk    (mclk),
      .reset_n (reset_n),
      .divider (ctrl.latch_pulse_divider),
      .pulse   (gen_pulse)
   );

   // Pin is asynchronous; a change counts once the last two stages agree
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ext_sync <= 3'h0;
      end else begin
         ext_sync <= {ext_sync[1:0], external_latch_input};
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ext_level <= 1'b0;
      end else if (ext_sync[1] == ext_sync[2]) begin
         ext_level <= ext_sync[2];
      end
   end

   // ------------------------------------------------------------
   // Latch
   // ------------------------------------------------------------
   assign set_in = soft_set_pulse | src_in.c1_set | src_in.c2_set
                   | (src_in.ext_set & ext_level)
                   | (set_clock_enable & gen_pulse);
   assign reset_in = soft_reset_pulse | src_in.c1_reset | src_in.c2_reset
                     | (src_in.ext_reset & ext_level);

   // State not reset: stays at whatever it held until set or reset
   // Clocked, not transparent, so a set/reset race resolves in one mclk
   always_ff @(posedge mclk) begin
      if (ctrl.latch_enable_bit) begin
         if (reset_in) begin
            latch_q <= 1'b0;
         end else if (set_in) begin
            latch_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Output pins; enable low while driving
   // ------------------------------------------------------------
   // True output and its driver enable
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         true_output_pin  <= 1'b0;
         true_output_oe_n <= 1'b1;
      end else begin
         true_output_pin  <= latch_q;
         true_output_oe_n <= !(ctrl.latch_enable_bit && ctrl.true_output_enable);
      end
   end

   // Independent of the true side, so both may be on pins at once
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         inverted_output_pin  <= 1'b0;
         inverted_output_oe_n <= 1'b1;
      end else begin
         inverted_output_pin  <= ~latch_q;
         inverted_output_oe_n <= !(ctrl.latch_enable_bit && ctrl.inverted_output_enable);
      end
   end
endmodule

// ---- verification/srlc_pin_model.sv ----
module srlc_pin_model (
   input  wire logic pin_value,
   input  wire logic pin_oe_n,
   input  wire logic pin_direction_bit,
   output logic      pad
);
   timeunit 1ns;
   timeprecision 1ps;
   // Driver off or pin an input: the pad's pull-down wins
   assign pad = (!pin_direction_bit && !pin_oe_n) ? pin_value : 1'b0;
endmodule

// ---- verification/srlc_monitor.sv ----
module srlc_monitor
   import srlc_pkg::*;
(
   input wire logic        mclk,
   input wire logic        reset_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        true_output_pin,
   input wire logic        true_output_oe_n,
   input wire logic        inverted_output_pin,
   input wire logic        inverted_output_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   wire ctl_wr = psel && penable && pwrite && pstrb[0] && paddr == LATCH_CONTROL_0_OFFS;
   sequence oe_written;
      ctl_wr && pwdata[7] ##2 1'b1;
   endsequence
   reset_clear_a: assert property (disable iff (1'b0) !reset_n |=> true_output_oe_n && prdata == '0)
      else $error("outputs not cleared by reset");
   soft_read_a: assert property (psel && !penable && !pwrite && paddr == 12'h000 |=> prdata[1:0] == 2'b00)
      else $error("pulse bits read back nonzero");
   disable_oe_a: assert property (ctl_wr && !pwdata[7] |-> ##2 true_output_oe_n && inverted_output_oe_n)
      else $error("output driven while latch disabled");
   true_oe_a: assert property (oe_written |-> true_output_oe_n == !$past(pwdata[3], 2))
      else $error("true output enable wrong");
   inv_oe_a: assert property (oe_written |-> inverted_output_oe_n == !$past(pwdata[2], 2))
      else $error("inverted output enable wrong");
   both_out_a: assert property (!true_output_oe_n && !inverted_output_oe_n |-> true_output_pin != inverted_output_pin)
      else $error("outputs not complementary");
   soft_set_a: assert property (ctl_wr && pwdata[7] && pwdata[1:0] == 2'b10 |-> ##[1:8] true_output_pin)
      else $error("soft set had no effect");
   soft_reset_a: assert property (ctl_wr && pwdata[7] && pwdata[0] |-> ##[1:8] !true_output_pin)
      else $error("soft reset had no effect");
endmodule

bind srlc_top srlc_monitor mon (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
   .true_output_pin, .true_output_oe_n, .inverted_output_pin, .inverted_output_oe_n);

// ---- verification/srlc_top_tb.sv ----
module srlc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import srlc_pkg::*;
   logic        mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, ext = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic        pready, pslverr, tq, tq_oe_n, nq, nq_oe_n, t_pad, n_pad;
   srlc_src_t   src = '0;
   int          fails = 0, compares = 0, cyc = 0, t1;

   srlc_top dut (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready,
      .pslverr, .src_in(src), .external_latch_input(ext), .true_output_pin(tq), .true_output_oe_n(tq_oe_n),
      .inverted_output_pin(nq), .inverted_output_oe_n(nq_oe_n));
   srlc_pin_model pin_t (.pin_value(tq), .pin_oe_n(tq_oe_n), .pin_direction_bit(1'b0), .pad(t_pad));
   srlc_pin_model pin_n (.pin_value(nq), .pin_oe_n(nq_oe_n), .pin_direction_bit(1'b0), .pad(n_pad));

   initial forever #5 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Holds the request until pready is seen high at an edge
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      r = {pslverr, prdata};
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [32:0] r;
      xfer(1'b1, a, d, r);
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] exp);
      logic [32:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk("read data", exp[31:0], r[31:0]);
      chk("slave error", {31'h0, exp[32]}, {31'h0, r[32]});
   endtask

   task automatic settle;
      repeat (10) @(posedge mclk);
   endtask

   // Sampled right after an edge so cyc and the pad agree
   task automatic rise;
      while (t_pad !== 1'b0) @(posedge mclk);
      while (t_pad !== 1'b1) @(posedge mclk);
   endtask

   task automatic print_verdict;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      print_verdict;
   end

   initial begin
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      rd(LATCH_CONTROL_0_OFFS, 33'h0);
      rd(LATCH_CONTROL_1_OFFS, 33'h0);
      rd(12'h00c, 33'h1_0000_0000);
      wr(LATCH_CONTROL_0_OFFS, 32'h82);
      rd(LATCH_CONTROL_0_OFFS, 33'h80);
      wr(LATCH_CONTROL_0_OFFS, 32'h8c);
      settle;
      chk("true pad", 32'h1, {31'h0, t_pad});
      chk("inverted pad", 32'h0, {31'h0, n_pad});
      wr(LATCH_CONTROL_0_OFFS, 32'h8d);
      settle;
      chk("inverted pad", 32'h1, {31'h0, n_pad});
      wr(LATCH_CONTROL_0_OFFS, 32'h8e);
      wr(LATCH_CONTROL_0_OFFS, 32'h8f);
      settle;
      chk("true pad", 32'h0, {31'h0, t_pad});
      wr(LATCH_CONTROL_0_OFFS, 32'h0c);
      settle;
      chk("true oe_n", 32'h1, {31'h0, tq_oe_n});
      wr(LATCH_CONTROL_0_OFFS, 32'h88);
      settle;
      chk("inverted oe_n", 32'h1, {31'h0, nq_oe_n});
      src.c1_set <= 1'b1;
      repeat (2) @(posedge mclk);
      src.c1_set <= 1'b0;
      settle;
      chk("true pad", 32'h1, {31'h0, t_pad});
      rd(LATCH_STATUS_OFFS, 33'h1);
      src.ext_reset <= 1'b1;
      ext <= 1'b1;
      settle;
      chk("true pad", 32'h0, {31'h0, t_pad});
      src.ext_reset <= 1'b0;
      ext <= 1'b0;
      wr(LATCH_CONTROL_1_OFFS, 32'h1);
      rd(LATCH_CONTROL_1_OFFS, 33'h1);
      // One-cycle comparator reset between rises, so no generator pulse is lost
      for (int c = 0; c < 8; c++) begin
         wr(LATCH_CONTROL_0_OFFS, {24'h0, 1'b1, c[2:0], 4'b1001});
         rise;
         t1 = cyc;
         src.c2_reset <= 1'b1;
         @(posedge mclk);
         src.c2_reset <= 1'b0;
         rise;
         chk("pulse period", 32'h4 << c, cyc - t1);
      end
      wr(LATCH_CONTROL_1_OFFS, 32'h0);
      wr(LATCH_CONTROL_0_OFFS, 32'h89);
      settle;
      chk("true pad", 32'h0, {31'h0, t_pad});
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rd(LATCH_CONTROL_0_OFFS, 33'h0);
      rd(LATCH_CONTROL_1_OFFS, 33'h0);
      chk("true oe_n", 32'h1, {31'h0, tq_oe_n});
      print_verdict;
   end
endmodule
